// *** logic/sdfe_pkg.sv ***
// Purpose: shared constants and types of the sdram control-pin front end
// Assumes: commands encoded as {row strobe, column strobe, write strobe}
// Notes: active-low strobes, so an all-high code is the idle command
package sdfe_pkg;

    typedef enum logic [2:0] {
        SDFE_CMD_LOAD_MODE = 3'h0,
        SDFE_CMD_REFRESH = 3'h1,
        SDFE_CMD_PRECHARGE = 3'h2,
        SDFE_CMD_ACTIVATE = 3'h3,
        SDFE_CMD_WRITE = 3'h4,
        SDFE_CMD_READ = 3'h5,
        SDFE_CMD_TERMINATE = 3'h6,
        SDFE_CMD_NOP = 3'h7
    } sdfe_cmd_t;

    typedef enum logic [2:0] {
        SDFE_PWR_RUN = 3'h0,
        SDFE_PWR_SUSPEND = 3'h1,
        SDFE_PWR_ACT_PD = 3'h2,
        SDFE_PWR_PRE_PD = 3'h3,
        SDFE_PWR_SELF_REF = 3'h4
    } sdfe_pwr_t;

    localparam int SDFE_SCOPE_BIT = 10;
    localparam int SDFE_COL_W = 8;
    localparam int SDFE_BURST_DEF = 4;
    localparam int SDFE_FIFO_DEPTH = 32;
    localparam int SDFE_MASK_LAT = 2;
    localparam logic [3:0] SDFE_BANKS_RST = 4'h0;
    localparam logic [15:0] SDFE_DATA_RST = 16'h0000;
    localparam logic [11:0] SDFE_ADDR_RST = 12'h000;

endpackage

// *** logic/sdfe_top.sv ***
// Purpose: control-pin front end of a four-bank sdram, device side
// Assumes: pins are synchronous to I_REF_CLK; core answers a read beat one cycle later
// Notes: write beats leave through a fifo; read data is driven two cycles after its beat
// How it works
// - every input pin is captured on the rising clock edge only
// - each active edge steps the burst position and clocks the output registers
// - clock-gate high lets the clock act, low blocks it
// - gating enters precharge/active power-down, self refresh or clock suspend by state
// - clock-gate is synchronous except while power-down or self refresh lasts
// - receivers, clock included, are off in power-down and self refresh
// - device select low enables the decoder; high masks every command
// - with device select high, running bursts finish and masks still work
// - select, row, column and write strobes together form the command
// - write data under a high byte mask is not stored
// - read mask high puts that byte's drivers in high impedance two cycles later
// - wide variant: low mask governs lines 0-7, high mask lines 8-15
// - narrow variants: one mask governs all lines, low mask unconnected
// - bank select picks the bank for activate, read, write, precharge
// - precharge scope bit picks auto precharge or all-bank precharge

module sdfe_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    assign o_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign o_valid = wr_ptr_reg != rd_ptr_reg;
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule

module sdfe_top import sdfe_pkg::*; #(
    parameter int BURST_LEN = SDFE_BURST_DEF,
    parameter int FIFO_DEPTH = SDFE_FIFO_DEPTH,
    parameter bit SINGLE_MASK = 1'b0
) (
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic I_CKE,
    input wire logic I_CS_N,
    input wire logic I_RAS_N,
    input wire logic I_CAS_N,
    input wire logic I_WE_N,
    input wire logic [1:0] I_BANK_SELECT,
    input wire logic [11:0] I_ADDR,
    input wire logic I_LOW_BYTE_MASK,
    input wire logic I_HIGH_BYTE_MASK,
    input wire logic [15:0] I_DATA_LINES,
    output logic [15:0] O_DATA_LINES,
    output logic [1:0] O_DATA_LINES_OE_N,
    output logic O_CMD_VALID,
    output logic [2:0] O_CMD,
    output logic [1:0] O_CMD_BANK,
    output logic [11:0] O_CMD_ADDR,
    output logic O_AUTO_PRECHARGE,
    output logic O_PRECHARGE_ALL,
    output logic [3:0] O_BANK_OPEN,
    output logic [2:0] O_POWER_STATE,
    output logic O_RX_ENABLE,
    output logic O_RD_REQ,
    output logic [1:0] O_RD_BANK,
    output logic [SDFE_COL_W-1:0] O_RD_COL,
    input wire logic [15:0] I_RD_DATA,
    output logic O_WR_VALID,
    input wire logic I_WR_READY,
    output logic [15:0] O_WR_DATA,
    output logic [1:0] O_WR_BYTE_EN,
    output logic [1:0] O_WR_BANK,
    output logic [SDFE_COL_W-1:0] O_WR_COL,
    output logic O_WR_STALL
);
    localparam int WW = 2 + SDFE_COL_W + 2 + 16;
    if (BURST_LEN != 1 && BURST_LEN != 2 && BURST_LEN != 4 && BURST_LEN != 8) begin : g_bad_burst
        $error("burst length must be 1, 2, 4 or 8");
    end
    logic rst_meta_reg, rst_n;
    logic p_cs_n_reg, p_cke_reg;
    sdfe_cmd_t p_cmd_reg;
    logic [1:0] p_ba_reg, p_mask_reg;
    logic [11:0] p_addr_reg;
    logic [15:0] p_data_reg;
    logic cke_s1_reg, cke_s2_reg, cke_s3_reg;
    sdfe_pwr_t pwr_reg, pwr_next;
    logic act, rx_en, cmd_ok, start, beat, beat_rd, beat_wr, end_now, ap_now;
    logic [2:0] left_reg;
    logic rd_kind_reg, ap_reg;
    logic [1:0] bank_reg, beat_bank;
    logic [SDFE_COL_W-1:0] col_reg, beat_col;
    logic [3:0] open_reg;
    logic [1:0] drv1_reg, drv2_reg, mask_eff;
    logic [15:0] dout_reg;
    logic fifo_ready;
    logic [WW-1:0] fifo_out;
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end
    // pin capture; select and clock-gate forced high while receivers are off
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            p_cs_n_reg <= 1'b1;
            p_cke_reg <= 1'b1;
            p_cmd_reg <= SDFE_CMD_NOP;
            p_ba_reg <= 2'h0;
            p_addr_reg <= SDFE_ADDR_RST;
            p_mask_reg <= 2'h0;
            p_data_reg <= SDFE_DATA_RST;
        end else if (rx_en) begin
            p_cs_n_reg <= I_CS_N;
            p_cke_reg <= I_CKE;
            p_cmd_reg <= sdfe_cmd_t'({I_RAS_N, I_CAS_N, I_WE_N});
            p_ba_reg <= I_BANK_SELECT;
            p_addr_reg <= I_ADDR;
            p_mask_reg <= {I_HIGH_BYTE_MASK, I_LOW_BYTE_MASK};
            p_data_reg <= I_DATA_LINES;
        end else begin
            p_cs_n_reg <= 1'b1;
            p_cke_reg <= 1'b1;
        end
    end

    // wake path while receivers are off
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cke_s1_reg <= 1'b0;
            cke_s2_reg <= 1'b0;
            cke_s3_reg <= 1'b0;
        end else begin
            cke_s1_reg <= I_CKE;
            cke_s2_reg <= cke_s1_reg;
            cke_s3_reg <= cke_s2_reg;
        end
    end
    assign act = pwr_reg == SDFE_PWR_RUN;
    assign rx_en = act || pwr_reg == SDFE_PWR_SUSPEND;
    assign cmd_ok = act && !p_cs_n_reg;
    assign start = cmd_ok && (p_cmd_reg == SDFE_CMD_READ || p_cmd_reg == SDFE_CMD_WRITE);
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            SDFE_PWR_RUN: begin
                if (!p_cke_reg) begin
                    if (start || left_reg != 3'h0) begin
                        pwr_next = SDFE_PWR_SUSPEND;
                    end else if (cmd_ok && p_cmd_reg == SDFE_CMD_REFRESH) begin
                        pwr_next = SDFE_PWR_SELF_REF;
                    end else if (|open_reg) begin
                        pwr_next = SDFE_PWR_ACT_PD;
                    end else begin
                        pwr_next = SDFE_PWR_PRE_PD;
                    end
                end
            end
            SDFE_PWR_SUSPEND: begin
                if (p_cke_reg) begin
                    pwr_next = SDFE_PWR_RUN;
                end
            end
            SDFE_PWR_ACT_PD, SDFE_PWR_PRE_PD, SDFE_PWR_SELF_REF: begin
                if (cke_s2_reg && cke_s3_reg) begin
                    pwr_next = SDFE_PWR_RUN;
                end
            end
            default: pwr_next = SDFE_PWR_RUN;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= SDFE_PWR_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // burst position; runs on whatever device select does
    assign beat = act && (start || left_reg != 3'h0);
    assign beat_rd = beat && (start ? p_cmd_reg == SDFE_CMD_READ : rd_kind_reg);
    assign beat_wr = beat && !beat_rd;
    assign beat_bank = start ? p_ba_reg : bank_reg;
    assign beat_col = start ? p_addr_reg[SDFE_COL_W-1:0] : col_reg;
    assign ap_now = start ? p_addr_reg[SDFE_SCOPE_BIT] : ap_reg;
    assign end_now = beat && (start ? BURST_LEN == 1 : left_reg == 3'h1);

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            left_reg <= 3'h0;
            rd_kind_reg <= 1'b0;
            ap_reg <= 1'b0;
            bank_reg <= 2'h0;
            col_reg <= '0;
        end else if (act) begin
            if (start) begin
                left_reg <= 3'(BURST_LEN - 1);
                rd_kind_reg <= p_cmd_reg == SDFE_CMD_READ;
                ap_reg <= p_addr_reg[SDFE_SCOPE_BIT];
                bank_reg <= p_ba_reg;
                col_reg <= p_addr_reg[SDFE_COL_W-1:0] + SDFE_COL_W'(1);
            end else if (cmd_ok && p_cmd_reg == SDFE_CMD_TERMINATE) begin
                left_reg <= 3'h0;
            end else if (left_reg != 3'h0) begin
                left_reg <= left_reg - 3'h1;
                col_reg <= col_reg + SDFE_COL_W'(1);
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            open_reg <= SDFE_BANKS_RST;
        end else begin
            // auto precharge close must not be lost to an activate or precharge on another bank
            if (end_now && ap_now) begin
                open_reg[beat_bank] <= 1'b0;
            end
            if (cmd_ok && p_cmd_reg == SDFE_CMD_ACTIVATE) begin
                open_reg[p_ba_reg] <= 1'b1;
            end else if (cmd_ok && p_cmd_reg == SDFE_CMD_PRECHARGE) begin
                open_reg[p_ba_reg] <= 1'b0;
                if (p_addr_reg[SDFE_SCOPE_BIT]) begin
                    open_reg <= SDFE_BANKS_RST;
                end
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_CMD_VALID <= 1'b0;
            O_CMD <= SDFE_CMD_NOP;
            O_CMD_BANK <= 2'h0;
            O_CMD_ADDR <= SDFE_ADDR_RST;
            O_AUTO_PRECHARGE <= 1'b0;
            O_PRECHARGE_ALL <= 1'b0;
        end else begin
            O_CMD_VALID <= cmd_ok && p_cmd_reg != SDFE_CMD_NOP;
            O_CMD <= p_cmd_reg;
            O_CMD_BANK <= p_ba_reg;
            O_CMD_ADDR <= p_addr_reg;
            O_AUTO_PRECHARGE <= start && p_addr_reg[SDFE_SCOPE_BIT];
            O_PRECHARGE_ALL <= cmd_ok && p_cmd_reg == SDFE_CMD_PRECHARGE
                && p_addr_reg[SDFE_SCOPE_BIT];
        end
    end

    // per-byte mask: one pin serves both bytes on the narrow parts
    assign mask_eff = {p_mask_reg[1], SINGLE_MASK ? p_mask_reg[1] : p_mask_reg[0]};

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RD_REQ <= 1'b0;
            O_RD_BANK <= 2'h0;
            O_RD_COL <= '0;
            dout_reg <= SDFE_DATA_RST;
            drv1_reg <= 2'h0;
            drv2_reg <= 2'h0;
        end else begin
            O_RD_REQ <= beat_rd;
            O_RD_BANK <= beat_bank;
            O_RD_COL <= beat_col;
            if (O_RD_REQ) begin
                dout_reg <= I_RD_DATA;
            end
            if (act) begin
                drv1_reg <= beat_rd ? ~mask_eff : 2'h0;
                drv2_reg <= drv1_reg;
            end
        end
    end

    assign O_DATA_LINES = dout_reg;
    assign O_DATA_LINES_OE_N = ~drv2_reg;
    assign O_BANK_OPEN = open_reg;
    assign O_POWER_STATE = pwr_reg;
    assign O_RX_ENABLE = rx_en;
    assign O_WR_STALL = !fifo_ready;

    sdfe_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_valid(beat_wr),
        .o_ready(fifo_ready),
        .i_data({beat_bank, beat_col, ~mask_eff, p_data_reg}),
        .o_valid(O_WR_VALID),
        .i_ready(I_WR_READY),
        .o_data(fifo_out)
    );
    assign {O_WR_BANK, O_WR_COL, O_WR_BYTE_EN, O_WR_DATA} = fifo_out;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!rst_n);

    a_cs_masks_cmd: assert property (act && p_cs_n_reg |=> !O_CMD_VALID)
        else $error("command decoded with device select high");
    a_mask_hiz_lat: assert property ((beat_rd && mask_eff[0]) ##1 act
        |=> O_DATA_LINES_OE_N[0])
        else $error("masked read byte still driven");
    a_read_drive: assert property ((beat_rd && !mask_eff[1]) ##1 act
        |=> !O_DATA_LINES_OE_N[1])
        else $error("unmasked read byte not driven");
    a_pd_rx_off: assert property (pwr_reg inside {SDFE_PWR_ACT_PD, SDFE_PWR_PRE_PD,
        SDFE_PWR_SELF_REF} |-> !O_RX_ENABLE && !O_RD_REQ ##1 !O_CMD_VALID)
        else $error("receivers active in power-down");
    a_gate_low_stop: assert property (act && !p_cke_reg |=> !act)
        else $error("clock kept acting with gate low");
    a_suspend_burst: assert property (act && !p_cke_reg && start
        |=> pwr_reg == SDFE_PWR_SUSPEND)
        else $error("burst did not enter clock suspend");
    a_wake_sync: assert property (!rx_en && cke_s2_reg && cke_s3_reg |=> act)
        else $error("no wake after clock-gate agreed high");
    a_burst_cs_high: assert property (act && left_reg > 3'h1 && p_cs_n_reg
        |-> beat ##1 (act -> beat))
        else $error("burst stopped by device select high");
    a_bank_activate: assert property (cmd_ok && p_cmd_reg == SDFE_CMD_ACTIVATE
        |=> O_BANK_OPEN[$past(p_ba_reg)])
        else $error("activate did not open bank");
    a_precharge_all: assert property (cmd_ok && p_cmd_reg == SDFE_CMD_PRECHARGE
        && p_addr_reg[SDFE_SCOPE_BIT] |=> O_BANK_OPEN == 4'h0 && O_PRECHARGE_ALL)
        else $error("all-bank precharge left a bank open");
    a_write_mask: assert property (beat_wr && fifo_ready && !O_WR_VALID && mask_eff[0]
        |=> O_WR_VALID && !O_WR_BYTE_EN[0])
        else $error("masked write byte enabled");

    c_read_burst: cover property (beat_rd ##1 beat_rd ##1 beat_rd);
    c_write_masked: cover property (beat_wr && mask_eff == 2'h3);
    c_self_refresh: cover property (pwr_reg == SDFE_PWR_SELF_REF ##[1:20] act);
    c_suspend: cover property (pwr_reg == SDFE_PWR_SUSPEND);
endmodule

// *** testbench/sdfe_core_model.sv ***
// Purpose: core-side partner, serves read beats and drains the write fifo
// Assumes: read data must be valid in the cycle of the read request
// Notes: i_stall withholds the pop so the fifo can be filled
module sdfe_core_model (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_rd_req,
    input wire logic [1:0] i_rd_bank,
    input wire logic [7:0] i_rd_col,
    output logic [15:0] o_rd_data,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [15:0] i_wr_data,
    input wire logic [1:0] i_wr_byte_en,
    input wire logic [1:0] i_wr_bank,
    input wire logic [7:0] i_wr_col
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [27:0] popped [$];
    logic [15:0] junk = 16'h5a3c;
    // outside a request the bus shows a moving pattern, never stale data
    always_comb begin
        o_rd_data = i_rd_req ? {4'ha, 2'h0, i_rd_bank, i_rd_col} : junk;
        o_wr_ready = !i_stall;
    end
    always @(posedge i_clk) begin
        junk <= ~junk + 16'h0001;
        if (i_wr_valid && o_wr_ready) begin
            popped.push_back({i_wr_bank, i_wr_col, i_wr_byte_en, i_wr_data});
        end
    end
endmodule

// *** testbench/test_sdfe_top.sv ***
// Purpose: self-checking bench of the control-pin front end
// Assumes: pins driven by non-blocking assignment at the rising edge
// Notes: outputs are checked 1 ns after the edge that updates them
module test_sdfe_top import sdfe_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, cke = 1'b1, cs_n = 1'b1;
    logic [1:0] cbank, wbank, oe1_n;
    logic [11:0] caddr;
    logic [7:0] wcol;
    logic lm = 1'b0, hm = 1'b0, stall = 1'b0;
    logic [2:0] cmd = 3'h7;
    logic [1:0] ba = 2'h0;
    logic [11:0] addr = 12'h000;
    logic [15:0] dq = 16'h0000, rd_data, odq, wr_data;
    logic [1:0] oe_n, wr_be, rd_bank;
    logic [7:0] rd_col;
    logic [2:0] o_cmd, pwr;
    logic [3:0] banks;
    logic cmd_v, ap, pall, rx, rd_req, wr_v, wr_rdy, full;
    int n_fail = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    sdfe_top u_dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_CKE(cke), .I_CS_N(cs_n),
        .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_BANK_SELECT(ba),
        .I_ADDR(addr), .I_LOW_BYTE_MASK(lm), .I_HIGH_BYTE_MASK(hm), .I_DATA_LINES(dq),
        .O_DATA_LINES(odq), .O_DATA_LINES_OE_N(oe_n), .O_CMD_VALID(cmd_v), .O_CMD(o_cmd),
        .O_CMD_BANK(cbank), .O_CMD_ADDR(caddr), .O_AUTO_PRECHARGE(ap), .O_PRECHARGE_ALL(pall),
        .O_BANK_OPEN(banks), .O_POWER_STATE(pwr), .O_RX_ENABLE(rx), .O_RD_REQ(rd_req),
        .O_RD_BANK(rd_bank), .O_RD_COL(rd_col), .I_RD_DATA(rd_data), .O_WR_VALID(wr_v),
        .I_WR_READY(wr_rdy), .O_WR_DATA(wr_data), .O_WR_BYTE_EN(wr_be), .O_WR_BANK(wbank),
        .O_WR_COL(wcol), .O_WR_STALL(full));
    // narrow variant: one mask pin serves both bytes
    sdfe_top #(.SINGLE_MASK(1'b1)) u_dut_narrow (.I_REF_CLK(clk), .I_NRST(nrst), .I_CKE(cke),
        .I_CS_N(cs_n), .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_BANK_SELECT(ba),
        .I_ADDR(addr), .I_LOW_BYTE_MASK(lm), .I_HIGH_BYTE_MASK(hm), .I_DATA_LINES(dq),
        .O_DATA_LINES(), .O_DATA_LINES_OE_N(oe1_n), .O_CMD_VALID(), .O_CMD(), .O_CMD_BANK(),
        .O_CMD_ADDR(), .O_AUTO_PRECHARGE(), .O_PRECHARGE_ALL(), .O_BANK_OPEN(),
        .O_POWER_STATE(), .O_RX_ENABLE(), .O_RD_REQ(), .O_RD_BANK(), .O_RD_COL(),
        .I_RD_DATA(rd_data), .O_WR_VALID(), .I_WR_READY(wr_rdy), .O_WR_DATA(),
        .O_WR_BYTE_EN(), .O_WR_BANK(), .O_WR_COL(), .O_WR_STALL());
    sdfe_core_model u_core (.i_clk(clk), .i_stall(stall), .i_rd_req(rd_req),
        .i_rd_bank(rd_bank), .i_rd_col(rd_col), .o_rd_data(rd_data), .i_wr_valid(wr_v),
        .o_wr_ready(wr_rdy), .i_wr_data(wr_data), .i_wr_byte_en(wr_be),
        .i_wr_bank(wbank), .i_wr_col(wcol));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic put(input logic c_n, input logic [2:0] c, input logic [1:0] b,
        input logic [11:0] a);
        @(posedge clk);
        cs_n <= c_n;
        cmd <= c;
        ba <= b;
        addr <= a;
    endtask
    task automatic idle;
        @(posedge clk);
        cs_n <= 1'b1;
        cmd <= 3'h7;
    endtask
    task automatic t_decode;
        for (int c = 0; c < 7; c++) begin
            put(1'b1, c[2:0], 2'h0, 12'h000);
            idle;
            tick;
            chk(cmd_v, 1'b0, "deselected cmd");
            put(1'b0, c[2:0], 2'(c), 12'h000);
            idle;
            tick;
            chk({cmd_v, o_cmd, cbank}, {1'b1, c[2:0], 2'(c)}, "decode");
        end
        chk(banks[3], 1'b1, "activate bank");
    endtask
    task automatic t_read;
        logic [15:0] mk = 16'h0024;
        logic [15:0] ex, em;
        put(1'b0, 3'h3, 2'h2, 12'h055);
        put(1'b0, 3'h5, 2'h2, 12'h410);
        {hm, lm} <= mk[1:0];
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            cs_n <= 1'b1;
            cmd <= 3'h7;
            {hm, lm} <= mk[2*i+2 +: 2];
            #1;
            if (i == 1) chk({cmd_v, ap, cbank, caddr}, {2'h3, 2'h2, 12'h410}, "auto pre");
            if (i >= 1 && i <= 4) chk({rd_req, rd_bank, rd_col}, {3'h6, 8'(i + 15)}, "beat");
            if (i >= 2 && i <= 5) begin
                ex = {4'ha, 2'h0, 2'h2, 8'(i + 14)};
                em = {{8{mk[2*i-3]}}, {8{mk[2*i-4]}}};
                chk(oe_n, mk[2*i-4 +: 2], "read mask");
                chk(oe1_n, {2{mk[2*i-3]}}, "narrow mask");
                chk(odq | em, ex | em, "read data");
            end
        end
        chk({oe_n, banks[2]}, 3'h6, "burst end");
    endtask
    task automatic wr_burst(input logic [15:0] base, input logic [7:0] mk);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cs_n <= (i != 0);
            cmd <= (i == 0) ? 3'h4 : 3'h7;
            ba <= 2'h1;
            addr <= 12'h020;
            dq <= base + 16'(i);
            {hm, lm} <= mk[2*i +: 2];
        end
    endtask
    task automatic t_write;
        logic [7:0] m = 8'h24;
        logic [1:0] be;
        @(posedge clk);
        stall <= 1'b1;
        u_core.popped.delete();
        for (int k = 0; k < 8; k++) wr_burst(16'h1000 + 16'(k * 4), (k == 0) ? m : 8'h00);
        wr_burst(16'h2000, 8'h00);
        idle;
        repeat (3) tick;
        chk({full, wr_v}, 2'h3, "fifo full");
        @(posedge clk);
        stall <= 1'b0;
        for (int n = 0; n < 60 && wr_v !== 1'b0; n++) tick;
        chk(u_core.popped.size(), 32, "drained count");
        chk(wr_v, 1'b0, "fifo empty");
        for (int k = 0; k < 32; k++) begin
            be = (k < 4) ? ~m[2*k +: 2] : 2'h3;
            chk(u_core.popped[k], {2'h1, 8'(32 + k % 4), be, 16'h1000 + 16'(k)}, "write beat");
        end
    endtask
    task automatic lp(input logic [2:0] c, input logic [2:0] st);
        logic [3:0] b;
        @(posedge clk);
        cke <= 1'b0;
        cs_n <= 1'b0;
        cmd <= c;
        idle;
        tick;
        chk({pwr, rx}, {st, st < 3'h2}, "low power entry");
        b = banks;
        put(1'b0, 3'h3, 2'h3, 12'h000);
        idle;
        repeat (2) tick;
        chk({cmd_v, banks}, {1'b0, b}, "cmd while gated");
        @(posedge clk);
        cke <= 1'b1;
        for (int n = 0; n < 8 && pwr !== SDFE_PWR_RUN; n++) tick;
        chk({pwr, rx}, {SDFE_PWR_RUN, 1'b1}, "wake");
    endtask
    task automatic t_power;
        put(1'b0, 3'h2, 2'h0, 12'h400);
        idle;
        tick;
        chk({pall, banks}, 5'h10, "precharge all");
        lp(3'h7, SDFE_PWR_PRE_PD);
        lp(3'h1, SDFE_PWR_SELF_REF);
        put(1'b0, 3'h3, 2'h0, 12'h000);
        lp(3'h7, SDFE_PWR_ACT_PD);
        put(1'b0, 3'h5, 2'h0, 12'h000);
        lp(3'h7, SDFE_PWR_SUSPEND);
        lp(3'h5, SDFE_PWR_SUSPEND);
    endtask
    task automatic summarize;
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) tick;
        chk({oe_n, o_cmd, pwr, rx, banks}, {2'h3, 3'h7, 3'h0, 1'b1, 4'h0}, "reset");
        t_decode;
        t_read;
        t_write;
        t_power;
        summarize;
    end
endmodule
